/* File: verilog/ubg_gpio_port.sv */
// eight pin programmable port of the serial bridge device
//
// What this block does
// RL1: direction bit 0 input, 1 output
// RL2: direction write clears pending pin interrupt
// RL3: state read returns live level of pins
// RL4: state write drives output pins only
// RL5: input change interrupts only when enabled
// RL6: modem mode ignores upper enables, uses modem
// RL7: soft reset bit resets device, reads zero
// RL8: control bit 1 selects upper modem function
// RL9: unlatched: read or reversion clears interrupt
// RL10: latched: capture level, read, direction write or disable clears
// RL11: gpio mode hides modem status and dtr
// RL12: modem mode shows status, dtr follows control
// RL13: host reads state register for change status
// RL14: pending changes merge into one interrupt
`timescale 1ns/1ps
module ubg_gpio_port (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire ubg_pkg::ubg_reg_req_t i_req,
    output ubg_pkg::ubg_reg_rsp_t o_rsp,
    input wire logic [7:0] i_pin,
    output logic [7:0] o_pin,
    output logic [7:0] o_pin_oe,
    input wire logic i_modem_irq_en,
    input wire logic i_modem_dtr,
    output ubg_pkg::ubg_modem_t o_modem,
    output logic o_irq,
    output logic o_soft_reset
);
    import ubg_pkg::*;

    ubg_state_t st_ff;      // registered state
    ubg_state_t nxt_st;     // next state
    logic [7:0] mmask;      // pins under gpio control
    logic [7:0] live_en;    // enabled input pins
    logic [7:0] chg;        // filtered level changes
    logic [7:0] pendv;      // pending change per pin
    logic [7:0] rv;         // state read value
    logic rd_state;         // state register read
    logic wr_dir;           // direction register write
    logic [2:0] mchg;       // modem line changes
    logic [7:0] clr;        // pending flag clear per pin

    // next state: synchroniser, change detect, registers and pins
    always_comb
    begin
        nxt_st = st_ff;
        // three stage synchroniser, level accepted when stages agree
        // stage one feeds stage two alone, so metastability goes no further
        nxt_st.s1 = i_pin;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int n = 0; n < 8; n++)
        begin
            if (st_ff.s2[n] == st_ff.s3[n])
            begin
                nxt_st.flt[n] = st_ff.s3[n];
            end
        end
        nxt_st.prev = st_ff.flt;
        // a change is the filtered level differing from one cycle before
        chg = st_ff.flt ^ st_ff.prev;
        // upper pins leave gpio control in modem mode
        // pins given to the modem function never interrupt; of them only dtr drives
        mmask = st_ff.modem ? UBG_MASK_LOW : UBG_MASK_ALL;  // RL8 RL12
        // interrupt capable pins: enabled inputs under gpio control
        live_en = st_ff.ien & ~st_ff.dir & mmask;  // RL5 RL6
        // side effects of a state read take hold at the answer edge
        rd_state = i_req.rd && (i_req.addr == UBG_ADDR_STATE);
        wr_dir = i_req.wr && (i_req.addr == UBG_ADDR_DIR);
        // pending: latched flag or live difference to the read level
        // unlatched: a level back at its reference drops the request itself
        pendv = st_ff.latch ? st_ff.pend
                            : ((st_ff.flt ^ st_ff.ref_lvl) & live_en);  // RL9
        for (int n = 0; n < 8; n++)
        begin
            // read value: captured level while a latched change waits
            // output pins read back the level seen on the wire
            if (st_ff.latch && st_ff.pend[n])
            begin
                rv[n] = st_ff.cap[n];  // RL10
            end
            else
            begin
                rv[n] = st_ff.flt[n];  // RL3
            end
            // disabling a pin or making it an output forgets its change
            // reference level refreshed by read, direction write, disable
            if (rd_state || wr_dir || !live_en[n])
            begin
                nxt_st.ref_lvl[n] = st_ff.flt[n];  // RL2 RL9
            end
            // latched flag: clear first, then a new change sets it
            clr[n] = rd_state || wr_dir || !live_en[n] || !st_ff.latch;
            if (clr[n])
            begin
                nxt_st.pend[n] = 1'b0;  // RL2 RL10
            end
            // a new change sets the flag; the set wins over a clear
            if (chg[n] && live_en[n] && st_ff.latch)
            begin
                nxt_st.pend[n] = 1'b1;  // RL10
            end
            // capture only the change that raised the flag; later toggles
            // of a pin still pending must not overwrite the held level
            if (chg[n] && live_en[n] && st_ff.latch
                && (!st_ff.pend[n] || clr[n]))
            begin
                nxt_st.cap[n] = st_ff.flt[n];  // RL10
            end
        end
        // read answer, unmapped indices read zero
        nxt_st.rvalid = i_req.rd;
        unique case (i_req.addr)
            UBG_ADDR_DIR: nxt_st.rdata = st_ff.dir;
            UBG_ADDR_STATE: nxt_st.rdata = rv;  // RL3 RL13
            UBG_ADDR_IEN: nxt_st.rdata = st_ff.ien;
            // control reads mode and latch; the soft reset bit reads zero
            UBG_ADDR_CTRL: nxt_st.rdata = {6'h00, st_ff.modem, st_ff.latch};
            // a read of an unmapped index still gets a zero answer
            default: nxt_st.rdata = 8'h00;
        endcase
        if (!i_req.rd)
        begin
            nxt_st.rdata = 8'h00;
        end
        // register writes
        nxt_st.srst = 1'b0;
        if (i_req.wr)
        begin
            unique case (i_req.addr)
                UBG_ADDR_DIR: nxt_st.dir = i_req.wdata;  // RL1
                UBG_ADDR_STATE: nxt_st.out = i_req.wdata;  // RL4
                UBG_ADDR_IEN: nxt_st.ien = i_req.wdata;
                UBG_ADDR_CTRL:
                begin
                    nxt_st.latch = i_req.wdata[UBG_CTRL_LATCH_BIT];
                    nxt_st.modem = i_req.wdata[UBG_CTRL_MODEM_BIT];  // RL8
                end
                // unmapped indices and reserved bits change nothing
                default: nxt_st.srst = 1'b0;
            endcase
        end
        // pin drive: outputs under gpio control, dtr in modem mode
        nxt_st.oe = st_ff.dir & mmask;  // RL1 RL12
        nxt_st.pin = st_ff.out & st_ff.dir & mmask;  // RL4
        if (st_ff.modem)
        begin
            // dtr is active low: a set control bit pulls the pin low
            nxt_st.oe = nxt_st.oe | UBG_MASK_DTR;
            nxt_st.pin[UBG_PIN_DTR] = ~i_modem_dtr;  // RL12
        end
        // one interrupt for all pending pin changes
        // any enabled pending pin keeps the shared line up
        nxt_st.irq = |pendv;  // RL14
        // modem lines: active low pins, hidden in gpio mode
        mchg = {chg[UBG_PIN_RI], chg[UBG_PIN_CD], chg[UBG_PIN_DSR]};
        if (st_ff.modem)
        begin
            nxt_st.mdm = ~{st_ff.flt[UBG_PIN_RI], st_ff.flt[UBG_PIN_CD],
                           st_ff.flt[UBG_PIN_DSR]};  // RL12
            // a change counts only while the modem interrupt is enabled
            nxt_st.mdm_chg = i_modem_irq_en && (|mchg);  // RL6 RL12
        end
        else
        begin
            nxt_st.mdm = 3'h0;  // RL11
            nxt_st.mdm_chg = 1'b0;  // RL11
        end
        // soft reset: return to reset values, keep the live pin view;
        // placed last so that pins, interrupt and modem outputs also go
        // back to idle one cycle after the write
        if (i_req.wr && (i_req.addr == UBG_ADDR_CTRL)
            && i_req.wdata[UBG_CTRL_SRST_BIT])
        begin
            nxt_st = UBG_ST_RST;  // RL7
            nxt_st.dir = UBG_DIR_RST;
            nxt_st.out = UBG_STATE_RST;
            nxt_st.ien = UBG_IEN_RST;
            nxt_st.latch = UBG_LATCH_RST;
            nxt_st.modem = UBG_MODEM_RST;
            nxt_st.s1 = i_pin;
            nxt_st.s2 = st_ff.s1;
            nxt_st.s3 = st_ff.s2;
            nxt_st.flt = st_ff.flt;
            nxt_st.prev = st_ff.flt;
            nxt_st.ref_lvl = st_ff.flt;
            nxt_st.rvalid = i_req.rd;  // a read taken alongside is answered
            nxt_st.srst = 1'b1;  // RL7
        end
    end

    // state register, frozen while the clock enable is low
    // the synchroniser freezes too, so pin pulses that come and go while
    // the port is frozen are never seen
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_ff <= UBG_ST_RST;
        end
        else if (i_ce)
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign o_rsp.rdata = st_ff.rdata;
    assign o_rsp.rvalid = st_ff.rvalid;
    assign o_pin = st_ff.pin;
    assign o_pin_oe = st_ff.oe;
    assign o_modem.lines = st_ff.mdm;
    assign o_modem.change = st_ff.mdm_chg;
    assign o_irq = st_ff.irq;
    assign o_soft_reset = st_ff.srst;

endmodule : ubg_gpio_port

/* File: verilog/ubg_pkg.sv */
// shared types and constants of the serial bridge pin port
package ubg_pkg;

    // register indices on the device's internal register port
    localparam logic [3:0] UBG_ADDR_DIR = 4'ha;  // pin_direction
    localparam logic [3:0] UBG_ADDR_STATE = 4'hb;  // pin_state
    localparam logic [3:0] UBG_ADDR_IEN = 4'hc;  // pin_change_irq_enable
    localparam logic [3:0] UBG_ADDR_CTRL = 4'he;  // pin_port_control

    // field positions inside pin_port_control
    localparam int UBG_CTRL_LATCH_BIT = 0;  // input_latch_enable
    localparam int UBG_CTRL_MODEM_BIT = 1;  // upper pins as modem lines
    localparam int UBG_CTRL_SRST_BIT = 3;  // soft_reset_bit

    // pin positions of the modem lines when modem mode is on
    localparam int UBG_PIN_DSR = 4;
    localparam int UBG_PIN_DTR = 5;
    localparam int UBG_PIN_CD = 6;
    localparam int UBG_PIN_RI = 7;

    // masks for all pins, the lower pin group and the dtr pin
    localparam logic [7:0] UBG_MASK_ALL = 8'hff;
    localparam logic [7:0] UBG_MASK_LOW = 8'h0f;
    localparam logic [7:0] UBG_MASK_DTR = 8'h20;

    // reset values of the software visible registers
    localparam logic [7:0] UBG_DIR_RST = 8'h00;
    localparam logic [7:0] UBG_STATE_RST = 8'h00;
    localparam logic [7:0] UBG_IEN_RST = 8'h00;
    localparam logic UBG_LATCH_RST = 1'b0;
    localparam logic UBG_MODEM_RST = 1'b0;

    // one register port request, sampled every enabled clock
    typedef struct packed {
        logic [3:0] addr;   // register index
        logic wr;           // write strobe, one cycle
        logic rd;           // read strobe, one cycle
        logic [7:0] wdata;  // write data
    } ubg_reg_req_t;

    // read answer
    typedef struct packed {
        logic [7:0] rdata;  // read data
        logic rvalid;       // one-cycle answer pulse
    } ubg_reg_rsp_t;

    // modem side of the block
    typedef struct packed {
        logic [2:0] lines;  // asserted ri, cd, dsr (1 = line active)
        logic change;       // modem status change pulse
    } ubg_modem_t;

    // whole state of the port
    typedef struct packed {
        logic [7:0] s1;       // synchroniser stage one
        logic [7:0] s2;       // synchroniser stage two
        logic [7:0] s3;       // synchroniser stage three
        logic [7:0] flt;      // filtered pin level
        logic [7:0] prev;     // filtered level one cycle ago
        logic [7:0] ref_lvl;  // level seen at the last state read, direction write or disable
        logic [7:0] pend;     // latched pending change
        logic [7:0] cap;      // captured level of a latched change
        logic [7:0] dir;      // pin_direction
        logic [7:0] out;      // pin_state write value
        logic [7:0] ien;      // pin_change_irq_enable
        logic latch;          // input_latch_enable
        logic modem;          // upper pins in modem mode
        logic [7:0] rdata;    // read data
        logic rvalid;         // read answer
        logic [7:0] pin;      // pin output level
        logic [7:0] oe;       // pin output enable
        logic irq;            // pin change interrupt
        logic [2:0] mdm;      // modem line levels
        logic mdm_chg;        // modem change pulse
        logic srst;           // soft reset pulse to the device
    } ubg_state_t;

    localparam ubg_state_t UBG_ST_RST = '0;

endpackage : ubg_pkg

/* File: sim/ubg_pin_model.sv */
// far-side model: outside drivers meeting the port's eight pins
`timescale 1ns/1ps
module ubg_pin_model (
    input wire logic [7:0] i_ext,
    input wire logic [7:0] i_pin_out,
    input wire logic [7:0] i_pin_oe,
    output logic [7:0] o_wire
);
    // an enabled pin owns its wire, elsewhere the outside level shows
    assign o_wire = (i_pin_out & i_pin_oe) | (i_ext & ~i_pin_oe);
endmodule : ubg_pin_model

/* File: sim/ubg_gpio_port_assertions.sv */
// port-level assertions of the serial bridge pin port
`timescale 1ns/1ps
module ubg_gpio_port_assertions (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire ubg_pkg::ubg_reg_req_t i_req,
    input wire ubg_pkg::ubg_reg_rsp_t o_rsp,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] o_pin,
    input wire logic [7:0] o_pin_oe,
    input wire logic i_modem_irq_en,
    input wire logic i_modem_dtr,
    input wire ubg_pkg::ubg_modem_t o_modem,
    input wire logic o_irq,
    input wire logic o_soft_reset
);
    import ubg_pkg::*;
    logic ctl_wr; // control write taken at this edge
    logic modem_ff; // mode bit as the host last set it
    assign ctl_wr = i_ce && i_req.wr && i_req.addr == UBG_ADDR_CTRL;
    // track the mode; a soft reset write returns it to gpio
    always_ff @(posedge i_core_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            modem_ff <= 1'b0;
        else if (ctl_wr)
            modem_ff <= i_req.wdata[1] && !i_req.wdata[3];
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    rd_answer_a: assert property (i_ce && i_req.rd |=> o_rsp.rvalid)
        else $error("read got no answer");
    no_stray_a: assert property (!(i_ce && i_req.rd) |=> !o_rsp.rvalid)
        else $error("answer without read");
    srst_pulse_a: assert property (ctl_wr && i_req.wdata[3]
        |=> o_soft_reset ##1 !o_soft_reset) else $error("bad reset pulse");
    srst_cause_a: assert property ($rose(o_soft_reset)
        |-> $past(ctl_wr && i_req.wdata[3])) else $error("stray reset");
    undriven_low_a: assert property ((o_pin & ~o_pin_oe) == 8'h00)
        else $error("level on undriven pin");
    gpio_quiet_a: assert property (!modem_ff [*3]
        |-> o_modem.lines == 3'h0 && !o_modem.change)
        else $error("modem lines seen in gpio mode");
    dtr_follow_a: assert property ((modem_ff && $stable(i_modem_dtr)) [*3]
        |-> o_pin_oe[5] && o_pin[5] == !i_modem_dtr)
        else $error("dtr pin not following control");
    mdm_chg_en_a: assert property (o_modem.change |-> $past(i_modem_irq_en))
        else $error("modem change while disabled");
    cover property (o_irq);
    cover property (o_modem.change);
    cover property (o_soft_reset);
endmodule : ubg_gpio_port_assertions
bind ubg_gpio_port ubg_gpio_port_assertions u_ubg_gpio_port_assertions (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
    .o_rsp(o_rsp), .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
    .i_modem_irq_en(i_modem_irq_en), .i_modem_dtr(i_modem_dtr),
    .o_modem(o_modem), .o_irq(o_irq), .o_soft_reset(o_soft_reset));

/* File: sim/uart_bridge_gpio_port_bench.sv */
// self-checking bench of the serial bridge pin port
`timescale 1ns/1ps
module uart_bridge_gpio_port_bench;
    import ubg_pkg::*;
    typedef struct packed { logic [7:0] dir, st, ext, rd; } ubg_row_t;
    logic i_core_clk, i_rst_n, i_ce, i_modem_irq_en, i_modem_dtr;
    logic o_irq, o_soft_reset; // design flags
    ubg_reg_req_t i_req; // register request
    ubg_reg_rsp_t o_rsp; // register answer
    ubg_modem_t o_modem; // modem side
    logic [7:0] ext, pin_w, o_pin, o_pin_oe; // pins
    int miscompares, checked;
    // direction, state write, outside level, expected state read
    ubg_row_t rows [4] = '{'{8'h00, 8'hff, 8'ha5, 8'ha5},
        '{8'hff, 8'h3c, 8'h00, 8'h3c}, '{8'h0f, 8'h05, 8'hf0, 8'hf5},
        '{8'hf0, 8'ha0, 8'h0f, 8'haf}};
    ubg_gpio_port u_ubg_gpio_port (.i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req), .o_rsp(o_rsp),
        .i_pin(pin_w), .o_pin(o_pin), .o_pin_oe(o_pin_oe),
        .i_modem_irq_en(i_modem_irq_en), .i_modem_dtr(i_modem_dtr),
        .o_modem(o_modem), .o_irq(o_irq), .o_soft_reset(o_soft_reset));
    ubg_pin_model u_ubg_pin_model (.i_ext(ext), .i_pin_out(o_pin),
        .i_pin_oe(o_pin_oe), .o_wire(pin_w));
    // 100 ns core clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    // print the counts and the verdict, then stop
    task automatic report_and_stop;
        $display("miscompares=%0d checked=%0d", miscompares, checked);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // compare one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // step n edges, then drive 1 ns later
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : tick
    // one write, then a free cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        i_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        tick(1);
        i_req.wr = 1'b0;
        tick(1);
    endtask : wr
    // one read; the answer must come at the next edge
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        i_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        tick(1);
        chk({7'h00, o_rsp.rvalid}, 8'h01);
        chk(o_rsp.rdata, e);
        i_req.rd = 1'b0;
        tick(1);
    endtask : rdc
    // bounded wait for the interrupt (0) or modem change (1)
    task automatic wait_sig(input int sel, input logic v);
        int n = 0;
        while ((sel == 0 ? o_irq : o_modem.change) !== v && n < 12)
        begin
            tick(1);
            n++;
        end
        chk({7'h00, sel == 0 ? o_irq : o_modem.change}, {7'h00, v});
        if ((sel == 0 ? o_irq : o_modem.change) !== v)
            report_and_stop();
    endtask : wait_sig
    // the interrupt must be low after eight cycles
    task automatic quiet;
        tick(8);
        chk({7'h00, o_irq}, 8'h00);
    endtask : quiet
    initial
    begin
        miscompares = 0;
        checked = 0;
        i_rst_n = 1'b0;
        i_ce = 1'b1;
        i_req = '0;
        ext = 8'h00;
        i_modem_irq_en = 1'b0;
        i_modem_dtr = 1'b0;
        tick(10);
        i_rst_n = 1'b1;
        // reset values, then an unmapped index
        rdc(UBG_ADDR_DIR, UBG_DIR_RST);
        rdc(UBG_ADDR_CTRL, 8'h00);
        rdc(4'h0, 8'h00);
        // ordinary direction and level cases
        foreach (rows[i])
        begin
            wr(UBG_ADDR_DIR, rows[i].dir);
            wr(UBG_ADDR_STATE, rows[i].st);
            ext = rows[i].ext;
            tick(8);
            chk(o_pin_oe, rows[i].dir);
            chk(o_pin, rows[i].st & rows[i].dir);
            rdc(UBG_ADDR_STATE, rows[i].rd);
        end
        // unlatched change interrupts on pin 0 only
        wr(UBG_ADDR_DIR, 8'h00);
        ext = 8'h00;
        tick(8);
        rdc(UBG_ADDR_STATE, 8'h00);
        wr(UBG_ADDR_IEN, 8'h01);
        ext = 8'h02;
        quiet();
        ext = 8'h03;
        wait_sig(0, 1'b1);
        ext = 8'h02;
        wait_sig(0, 1'b0);
        ext = 8'h03;
        wait_sig(0, 1'b1);
        rdc(UBG_ADDR_STATE, 8'h03);
        wait_sig(0, 1'b0);
        // latched: level held through a revert until read
        wr(UBG_ADDR_CTRL, 8'h01);
        ext = 8'h02;
        wait_sig(0, 1'b1);
        ext = 8'h03;
        tick(8);
        chk({7'h00, o_irq}, 8'h01);
        rdc(UBG_ADDR_STATE, 8'h02);
        wait_sig(0, 1'b0);
        // a direction write drops a pending change
        ext = 8'h02;
        wait_sig(0, 1'b1);
        wr(UBG_ADDR_DIR, 8'h00);
        wait_sig(0, 1'b0);
        // modem mode: upper enables ignored, dtr driven
        wr(UBG_ADDR_CTRL, 8'h02);
        wr(UBG_ADDR_IEN, 8'hf0);
        i_modem_dtr = 1'b1;
        ext = 8'h00;
        tick(8);
        chk({5'h00, o_modem.lines}, 8'h07);
        chk(o_pin_oe & 8'hf0, 8'h20);
        ext = 8'h80;
        quiet();
        i_modem_irq_en = 1'b1;
        ext = 8'h00;
        wait_sig(1, 1'b1);
        // soft reset pulses once, clears control, enable, pin enables and modem lines, and control reads back zero
        i_req = '{addr: UBG_ADDR_CTRL, wr: 1'b1, rd: 1'b0, wdata: 8'h08};
        tick(1);
        chk({7'h00, o_soft_reset}, 8'h01);
        i_req.wr = 1'b0;
        tick(1);
        chk({7'h00, o_soft_reset}, 8'h00);
        rdc(UBG_ADDR_CTRL, 8'h00);
        rdc(UBG_ADDR_IEN, UBG_IEN_RST);
        chk(o_pin_oe, 8'h00);
        chk({5'h00, o_modem.lines}, 8'h00);
        // clock enable low: a write is not taken
        i_ce = 1'b0;
        wr(UBG_ADDR_IEN, 8'h55);
        i_ce = 1'b1;
        rdc(UBG_ADDR_IEN, UBG_IEN_RST);
        report_and_stop();
    end
endmodule : uart_bridge_gpio_port_bench
